// ### include/otf_pkg.sv
// Constants for output turn-off and fault-retry control
// Function
// - Retry code 110 allows six restarts, then output stays off until cleared.
// - Retry code 111 restarts without limit until commanded off or other fault.
// - Restart spacing is set by the three-bit retry/delay field times unit.
// - Field value n decodes as two to the power n delay units.
// - Same count times continued operation after fault and restart spacing.
// - Delay unit length comes from separate configuration, not the response byte.
// - Start-up-timeout response uses the output-voltage fault delay unit.
// - Read/write 16-bit turn-off delay in ms, waited before ramp down.
// - Read/write 16-bit fall time in ms, ramp down after delay expires.
// - 16-bit ms limit; warn if output not below one eighth in time.
// - Bits 7:6 select ignore, continue then retry, disable-retry, latch off.
// - Retry codes 000 to 101 mean zero to five restarts; zero latches.
// - Latched fault clears by bit clear, clear-all, off-on cycle, bias loss.
package otf_pkg;
   localparam logic [7:0]  CMD_FAULT_ACTION = 8'h63;
   localparam logic [7:0]  CMD_OFF_DELAY    = 8'h64;
   localparam logic [7:0]  CMD_FALL_TIME    = 8'h65;
   localparam logic [7:0]  CMD_WARN_LIMIT   = 8'h66;
   localparam logic [7:0]  RST_FAULT_ACTION = 8'h00;
   localparam logic [15:0] RST_OFF_DELAY    = 16'h0000;
   localparam logic [15:0] RST_FALL_TIME    = 16'h0000;
   localparam logic [15:0] RST_WARN_LIMIT   = 16'h0000;
   localparam int          ACT_MSB          = 7;
   localparam int          ACT_LSB          = 6;
   localparam int          RETRY_MSB        = 5;
   localparam int          RETRY_LSB        = 3;
   localparam int          DLY_MSB          = 2;
   localparam int          DLY_LSB          = 0;
   localparam logic [1:0]  ACT_IGNORE       = 2'h0;
   localparam logic [1:0]  ACT_CONTINUE     = 2'h1;
   localparam logic [1:0]  ACT_RETRY        = 2'h2;
   localparam logic [1:0]  ACT_LATCH        = 2'h3;
   localparam logic [2:0]  RETRY_NONE       = 3'h0;
   localparam logic [2:0]  RETRY_FOREVER    = 3'h7;
   localparam int          TIMER_W          = 24;
   localparam int          CLK_PERIOD_PS    = 8000;
   localparam int          MS_PS            = 1000000000;
   localparam int          MS_CYCLES        = MS_PS / CLK_PERIOD_PS;
   localparam logic [15:0] UNIT_MS_DEFAULT  = 16'h0001;
   typedef enum logic [6:0] {
      ST_OFF   = 7'b0000001,
      ST_ON    = 7'b0000010,
      ST_CONT  = 7'b0000100,
      ST_WAIT  = 7'b0001000,
      ST_LATCH = 7'b0010000,
      ST_DLY   = 7'b0100000,
      ST_FALL  = 7'b1000000
   } otf_state_e;
endpackage

// ### src/otf_ms_timer.sv
// Millisecond tick and one-shot millisecond down-counter
`timescale 1ns/1ps
`default_nettype none
module otf_ms_timer
   import otf_pkg::*;
#(
   parameter int MS_TICKS = MS_CYCLES
) (
   input  wire logic               mclk,
   input  wire logic               rst_n,
   input  wire logic               ce,
   input  wire logic               start,
   input  wire logic [TIMER_W-1:0] loadMs,
   output logic                    msTick,
   output logic                    done
);
   logic [31:0]        pre_q;
   logic [TIMER_W-1:0] cnt_q;
   logic               busy_q;

   // Free-running prescaler, so a start may land up to one tick early
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pre_q  <= 32'h0;
         msTick <= 1'b0;
      end else if (ce) begin
         msTick <= (pre_q == 32'(MS_TICKS - 1));
         pre_q  <= (pre_q == 32'(MS_TICKS - 1)) ? 32'h0 : pre_q + 32'h1;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q  <= '0;
         busy_q <= 1'b0;
         done   <= 1'b0;
      end else if (ce) begin
         done <= 1'b0;
         if (start) begin
            cnt_q  <= loadMs;
            busy_q <= 1'b1;
         end else if (busy_q && cnt_q == '0) begin
            busy_q <= 1'b0;
            done   <= 1'b1;
         end else if (busy_q && msTick) begin
            cnt_q <= cnt_q - TIMER_W'(1);
         end
      end
   end
endmodule
`default_nettype wire

// ### src/otf_ctrl.sv
// Turn-off sequencing, power-down warning and start-up fault retry control
`timescale 1ns/1ps
`default_nettype none
module otf_ctrl
   import otf_pkg::*;
#(
   parameter int          MS_TICKS = MS_CYCLES,
   parameter logic [15:0] UNIT_MS  = UNIT_MS_DEFAULT
) (
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic        ce,
   input  wire logic        cmdValid,
   input  wire logic        cmdWrite,
   input  wire logic [7:0]  cmdCode,
   input  wire logic [15:0] cmdWdata,
   input  wire logic        enableReq,
   input  wire logic        startupFault,
   input  wire logic        faultPresent,
   input  wire logic        otherFault,
   input  wire logic        voutBelowEighth,
   input  wire logic        faultBitClear,
   input  wire logic        clearFaults,
   output logic [15:0]      rdData,
   output logic             rdValid,
   output logic             outEnable,
   output logic             rampFalling,
   output logic             faultLatched,
   output logic             powerDownWarn,
   output logic [2:0]       restartCount
);
   logic [7:0]         faultAction_q;
   logic [15:0]        offDelay_q;
   logic [15:0]        fallTime_q;
   logic [15:0]        warnLimit_q;
   otf_state_e         state_q;
   otf_state_e         state_d;
   logic               tmrStart;
   logic [TIMER_W-1:0] tmrLoad;
   logic               msTick;
   logic               tmrDone;
   logic [15:0]        warnCnt_q;
   logic               warnRun_q;
   logic               enablePrev_q;
   logic [1:0]         act;
   logic [2:0]         retryCode;
   logic [TIMER_W-1:0] retryMs;
   logic               retryAllowed;
   logic               offEdge;

   assign act       = faultAction_q[ACT_MSB:ACT_LSB];
   assign retryCode = faultAction_q[RETRY_MSB:RETRY_LSB];
   // Unit is the output-voltage fault unit, shifted by the field (2^n units)
   assign retryMs   = TIMER_W'(UNIT_MS) << faultAction_q[DLY_MSB:DLY_LSB];
   assign retryAllowed = (retryCode == RETRY_FOREVER) ||
                         (retryCode != RETRY_NONE && restartCount < retryCode);
   assign offEdge   = enablePrev_q && !enableReq;

   otf_ms_timer #(
      .MS_TICKS (MS_TICKS)
   ) u_timer (
      .mclk   (mclk),
      .rst_n  (rst_n),
      .ce     (ce),
      .start  (tmrStart),
      .loadMs (tmrLoad),
      .msTick (msTick),
      .done   (tmrDone)
   );

   // Register writes
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         faultAction_q <= RST_FAULT_ACTION;
         offDelay_q    <= RST_OFF_DELAY;
         fallTime_q    <= RST_FALL_TIME;
         warnLimit_q   <= RST_WARN_LIMIT;
      end else if (ce && cmdValid && cmdWrite) begin
         case (cmdCode)
            CMD_FAULT_ACTION: faultAction_q <= cmdWdata[7:0];
            CMD_OFF_DELAY:    offDelay_q    <= cmdWdata;
            CMD_FALL_TIME:    fallTime_q    <= cmdWdata;
            CMD_WARN_LIMIT:   warnLimit_q   <= cmdWdata;
            default: ;
         endcase
      end
   end

   // Register reads, unmapped codes answer zero
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rdData  <= 16'h0;
         rdValid <= 1'b0;
      end else if (ce) begin
         rdValid <= cmdValid && !cmdWrite;
         if (cmdValid && !cmdWrite) begin
            case (cmdCode)
               CMD_FAULT_ACTION: rdData <= {8'h0, faultAction_q};
               CMD_OFF_DELAY:    rdData <= offDelay_q;
               CMD_FALL_TIME:    rdData <= fallTime_q;
               CMD_WARN_LIMIT:   rdData <= warnLimit_q;
               default:          rdData <= 16'h0;
            endcase
         end
      end
   end

   // Sequencer
   always_comb begin
      state_d  = state_q;
      tmrStart = 1'b0;
      tmrLoad  = '0;
      case (state_q)
         ST_OFF: begin
            if (enableReq) begin
               state_d = ST_ON;
            end
         end
         ST_ON: begin
            if (!enableReq) begin
               state_d  = ST_DLY;
               tmrStart = 1'b1;
               tmrLoad  = TIMER_W'(offDelay_q);
            end else if (otherFault) begin
               state_d = ST_LATCH;
            end else if (startupFault) begin
               case (act)
                  ACT_IGNORE: state_d = ST_ON;
                  ACT_CONTINUE: begin
                     state_d  = ST_CONT;
                     tmrStart = 1'b1;
                     tmrLoad  = retryMs;
                  end
                  ACT_RETRY: begin
                     state_d  = retryAllowed ? ST_WAIT : ST_LATCH;
                     tmrStart = retryAllowed;
                     tmrLoad  = retryMs;
                  end
                  default: state_d = ST_LATCH;
               endcase
            end
         end
         ST_CONT: begin
            if (!enableReq) begin
               state_d  = ST_DLY;
               tmrStart = 1'b1;
               tmrLoad  = TIMER_W'(offDelay_q);
            end else if (otherFault) begin
               state_d = ST_LATCH;
            end else if (tmrDone) begin
               // Fault gone by the end of the window: keep running
               if (!faultPresent) begin
                  state_d = ST_ON;
               end else if (retryAllowed) begin
                  state_d  = ST_WAIT;
                  tmrStart = 1'b1;
                  tmrLoad  = retryMs;
               end else begin
                  state_d = ST_LATCH;
               end
            end
         end
         ST_WAIT: begin
            if (!enableReq) begin
               state_d = ST_OFF;
            end else if (otherFault) begin
               state_d = ST_LATCH;
            end else if (tmrDone) begin
               state_d = ST_ON;
            end
         end
         ST_LATCH: begin
            // Enable low here clears the latch at once, going straight to off
            if (faultBitClear || clearFaults || !enableReq) begin
               state_d = ST_OFF;
            end
         end
         ST_DLY: begin
            if (tmrDone) begin
               state_d  = ST_FALL;
               tmrStart = 1'b1;
               tmrLoad  = TIMER_W'(fallTime_q);
            end
         end
         ST_FALL: begin
            if (tmrDone) begin
               state_d = ST_OFF;
            end
         end
         default: state_d = ST_OFF;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_q      <= ST_OFF;
         enablePrev_q <= 1'b0;
      end else if (ce) begin
         state_q      <= state_d;
         enablePrev_q <= enableReq;
      end
   end

   // Restart attempt counter, reset by a fresh enable or a clear
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         restartCount <= 3'h0;
      end else if (ce) begin
         if (state_q == ST_OFF) begin
            restartCount <= 3'h0;
         end else if (state_q == ST_WAIT && state_d == ST_ON &&
                      retryCode != RETRY_FOREVER) begin
            restartCount <= restartCount + 3'h1;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         outEnable    <= 1'b0;
         rampFalling  <= 1'b0;
         faultLatched <= 1'b0;
      end else if (ce) begin
         outEnable    <= (state_d == ST_ON) || (state_d == ST_CONT) || (state_d == ST_DLY);
         rampFalling  <= (state_d == ST_FALL);
         faultLatched <= (state_d == ST_LATCH);
      end
   end

   // Power-down watchdog from the disable edge; a zero limit disables it
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         warnRun_q     <= 1'b0;
         warnCnt_q     <= 16'h0;
         powerDownWarn <= 1'b0;
      end else if (ce) begin
         if (offEdge) begin
            warnRun_q <= (warnLimit_q != 16'h0);
            warnCnt_q <= 16'h0;
         end else if (warnRun_q && voutBelowEighth) begin
            warnRun_q <= 1'b0;
         end else if (warnRun_q && msTick) begin
            warnCnt_q <= warnCnt_q + 16'h1;
            if (warnCnt_q + 16'h1 >= warnLimit_q) begin
               warnRun_q <= 1'b0;
            end
         end
         // Set wins over a clear in the same cycle
         if (warnRun_q && msTick && !voutBelowEighth && !offEdge &&
             warnCnt_q + 16'h1 >= warnLimit_q) begin
            powerDownWarn <= 1'b1;
         end else if (clearFaults || faultBitClear) begin
            powerDownWarn <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// ### testbench/otf_ctrl_properties.sv
// Port-level checks for the turn-off and fault-retry controller
`timescale 1ns/1ps
`default_nettype none
module otf_ctrl_chk (
   input wire logic       mclk,
   input wire logic       rst_n,
   input wire logic       ce,
   input wire logic       cmdValid,
   input wire logic       cmdWrite,
   input wire logic       enableReq,
   input wire logic       startupFault,
   input wire logic       otherFault,
   input wire logic       faultBitClear,
   input wire logic       clearFaults,
   input wire logic       rdValid,
   input wire logic       outEnable,
   input wire logic       rampFalling,
   input wire logic       faultLatched,
   input wire logic       powerDownWarn,
   input wire logic [2:0] restartCount
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   sequence s_read; ce && cmdValid && !cmdWrite; endsequence
   sequence s_turnOn;
      ce && $rose(enableReq) && !outEnable && !rampFalling && !faultLatched;
   endsequence
   sequence s_turnOff;
      ce && $fell(enableReq) && outEnable && !otherFault && !startupFault;
   endsequence
   a_read_answer: assert property (s_read |=> rdValid)
      else $error("read not answered");
   a_read_quiet: assert property (ce && !(cmdValid && !cmdWrite) |=> !rdValid)
      else $error("unrequested read answer");
   a_turn_on: assert property (s_turnOn |-> ##[1:3] outEnable)
      else $error("output not enabled");
   a_off_order: assert property (s_turnOff |=> outEnable || rampFalling)
      else $error("output dropped without delay");
   a_ramp_apart: assert property (rampFalling |-> !outEnable && !faultLatched)
      else $error("ramp overlaps other state");
   a_latch_hold: assert property (
      faultLatched && enableReq && !clearFaults && !faultBitClear |=> faultLatched && !outEnable)
      else $error("latched fault lost");
   a_warn_sticky: assert property (powerDownWarn && !clearFaults && !faultBitClear
      |=> powerDownWarn)
      else $error("warning not sticky");
   a_count_step: assert property ($changed(restartCount)
      |-> restartCount == $past(restartCount) + 3'h1 || restartCount == 3'h0)
      else $error("restart count jumped");
endmodule
bind otf_ctrl otf_ctrl_chk u_chk (.mclk(mclk), .rst_n(rst_n), .ce(ce), .cmdValid(cmdValid),
   .cmdWrite(cmdWrite), .enableReq(enableReq), .startupFault(startupFault),
   .otherFault(otherFault), .faultBitClear(faultBitClear), .clearFaults(clearFaults),
   .rdValid(rdValid), .outEnable(outEnable), .rampFalling(rampFalling),
   .faultLatched(faultLatched), .powerDownWarn(powerDownWarn), .restartCount(restartCount));
`default_nettype wire

// ### testbench/otf_host.sv
// Management host model issuing register commands
`timescale 1ns/1ps
`default_nettype none
module otf_host (
   input  wire logic   mclk,
   output logic        cmdValid,
   output logic        cmdWrite,
   output logic [7:0]  cmdCode,
   output logic [15:0] cmdWdata
);
   initial begin
      cmdValid = 1'h0;
      cmdWrite = 1'h0;
      cmdCode  = 8'h00;
      cmdWdata = 16'h0000;
   end
   // Idle code and data show inverted values so stale data is never mistaken for valid
   task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d);
      @(negedge mclk);
      cmdValid = 1'h1;
      cmdWrite = w;
      cmdCode  = c;
      cmdWdata = d;
      @(negedge mclk);
      cmdValid = 1'h0;
      cmdCode  = ~c;
      cmdWdata = ~d;
   endtask
endmodule
`default_nettype wire

// ### testbench/tb.sv
// Self-checking bench for the turn-off and fault-retry controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin nCompared++; if ((a) !== (e)) begin nMismatch++; \
   $display("ERROR %s expected %0h seen %0h", nm, e, a); end end
`define WAITC(x) begin k = 0; while (!(x) && k < 700) begin @(negedge mclk); k++; end end
module tb;
   import otf_pkg::*;
   localparam int MT = 4;
   logic        mclk = 1'h0, rst_n = 1'h0, enableReq = 1'h0, startupFault = 1'h0;
   logic        faultPresent = 1'h0, otherFault = 1'h0, voutBelowEighth = 1'h0;
   logic        faultBitClear = 1'h0, clearFaults = 1'h0, ce = 1'h1;
   logic        cmdValid, cmdWrite, rdValid, outEnable, rampFalling, faultLatched;
   logic        powerDownWarn;
   logic [7:0]  cmdCode, c;
   logic [15:0] cmdWdata, rdData, r;
   logic [2:0]  restartCount;
   logic [7:0]  acts [8] = '{8'h00, 8'hb1, 8'hb8, 8'h80, 8'h9a, 8'he8, 8'h41, 8'h41};
   logic        lat [8] = '{1'h0, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0};
   logic [2:0]  cnt [8] = '{3'h0, 3'h6, 3'h0, 3'h0, 3'h3, 3'h0, 3'h0, 3'h0};
   int          np [8] = '{1, 7, 8, 1, 4, 1, 1, 1};
   int          seed = 4686, nMismatch = 0, nCompared = 0, k = 0, cyc = 0, d, f;
   initial begin
      forever #4 mclk = ~mclk;
   end
   otf_host host (.mclk(mclk), .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdCode(cmdCode),
      .cmdWdata(cmdWdata));
   otf_ctrl #(.MS_TICKS(MT), .UNIT_MS(16'h0001)) uut (.mclk(mclk), .rst_n(rst_n), .ce(ce),
      .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdCode(cmdCode), .cmdWdata(cmdWdata),
      .enableReq(enableReq), .startupFault(startupFault), .faultPresent(faultPresent),
      .otherFault(otherFault), .voutBelowEighth(voutBelowEighth), .faultBitClear(faultBitClear),
      .clearFaults(clearFaults), .rdData(rdData), .rdValid(rdValid), .outEnable(outEnable),
      .rampFalling(rampFalling), .faultLatched(faultLatched), .powerDownWarn(powerDownWarn),
      .restartCount(restartCount));
   // Millisecond timing is quantised to a free tick, so allow one tick short
   function automatic bit okMs(input int n, input int ms);
      return n >= (ms - 1) * MT && n <= ms * MT + 4;
   endfunction
   task automatic rc(input logic [7:0] a, input logic [15:0] e);
      host.xfer(1'h0, a, 16'h0000);
      // Answer stands for one cycle only, so look at the first falling edge after it
      `CHK("rdValid", 1'h1, rdValid)
      `CHK("rdData", e, rdData)
   endtask
   task automatic on1;
      @(negedge mclk);
      enableReq = 1'h1;
      voutBelowEighth = 1'h0;
      `WAITC(outEnable)
      `CHK("on", 1'h1, outEnable)
   endtask
   task automatic off1(input int dl, input int fl, input logic vb, input logic w);
      @(negedge mclk);
      enableReq = 1'h0;
      // A latched fault leaves on the next edge, with the output already off
      `WAITC(!outEnable && !faultLatched)
      if (dl >= 0) `CHK("delay", 1'h1, okMs(k, dl))
      voutBelowEighth = vb;
      `WAITC(!rampFalling)
      if (fl >= 0) `CHK("fall", 1'h1, okMs(k, fl))
      `CHK("warn", w, powerDownWarn)
      `CHK("offAll", 3'h0, {outEnable, rampFalling, faultLatched})
   endtask
   task automatic pulse(ref logic s);
      @(negedge mclk);
      s = 1'h1;
      @(negedge mclk);
      s = 1'h0;
   endtask
   task automatic printVerdict;
      $display("Comparisons %0d mismatches %0d", nCompared, nMismatch);
      if (nMismatch == 0 && nCompared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         nMismatch++;
         printVerdict;
      end
   end
   initial begin
      repeat (3) @(negedge mclk);
      `CHK("rstOut", 7'h00, {outEnable, rampFalling, faultLatched, powerDownWarn, restartCount})
      rst_n = 1'h1;
      for (int a = 8'h63; a <= 8'h66; a++) rc(a[7:0], 16'h0000);
      // Clock enable ce low must freeze the registers, so this write is lost
      ce = 1'h0;
      host.xfer(1'h1, CMD_OFF_DELAY, 16'h1234);
      ce = 1'h1;
      rc(CMD_OFF_DELAY, 16'h0000);
      repeat (8) begin
         c = CMD_FAULT_ACTION + 8'($random(seed) & 3);
         r = 16'($random(seed));
         host.xfer(1'h1, c, r);
         rc(c, (c == CMD_FAULT_ACTION) ? {8'h00, r[7:0]} : r);
      end
      rc(8'h70, 16'h0000);
      $display("Test registers done");
      for (int i = 0; i < 2; i++) begin
         d = 1 + ($random(seed) & 1);
         f = 2 + ($random(seed) & 1);
         host.xfer(1'h1, CMD_OFF_DELAY, 16'(d));
         host.xfer(1'h1, CMD_FALL_TIME, 16'(f));
         host.xfer(1'h1, CMD_WARN_LIMIT, i ? 16'h0001 : 16'h0028);
         on1;
         off1(d, f, !i, i[0]);
      end
      pulse(faultBitClear);
      @(negedge mclk);
      `CHK("warnClear", 1'h0, powerDownWarn)
      host.xfer(1'h1, CMD_WARN_LIMIT, 16'h0000);
      $display("Test turn-off done");
      for (int i = 0; i < 8; i++) begin
         host.xfer(1'h1, CMD_FAULT_ACTION, {8'h00, acts[i]});
         faultPresent = (i == 6);
         on1;
         for (int p = 0; p < np[i]; p++) begin
            pulse(startupFault);
            `WAITC(!outEnable || faultLatched)
            if (i == 6) `CHK("cont", 1'h1, okMs(k, 1 << acts[i][2:0]))
            if (faultLatched === 1'h0 && acts[i][7] === 1'h1) begin
               `WAITC(outEnable || faultLatched)
               if (outEnable === 1'h1) `CHK("gap", 1'h1, okMs(k, 1 << acts[i][2:0]))
            end
         end
         if (i == 2) begin
            pulse(otherFault);
            `WAITC(faultLatched)
         end
         `CHK("latched", lat[i], faultLatched)
         if (i != 2) `CHK("count", cnt[i], restartCount)
         if (!lat[i]) `CHK("stayOn", 1'h1, outEnable)
         if (lat[i] && i[0]) begin
            pulse(clearFaults);
            @(negedge mclk);
            `CHK("clear", 1'h0, faultLatched)
         end
         off1(-1, -1, 1'h1, 1'h0);
      end
      $display("Test faults done");
      printVerdict;
   end
endmodule
`default_nettype wire
